/* include/nic_regs_pkg.sv */
// Register map, field positions and reset values of the host register bank
package nic_regs_pkg;
	localparam int DATA_W = 16;
	localparam int SEL_W = 6;
	localparam int REG_COUNT = 64;
	localparam int TALLY_COUNT = 3;
	// Command and status group
	localparam logic [5:0] REG_COMMAND = 6'h00;
	localparam logic [5:0] REG_DATA_CONFIG = 6'h01;
	localparam logic [5:0] REG_RECEIVE_CONTROL = 6'h02;
	localparam logic [5:0] REG_TRANSMIT_CONTROL = 6'h03;
	localparam logic [5:0] REG_INTERRUPT_MASK = 6'h04;
	localparam logic [5:0] REG_INTERRUPT_STATUS = 6'h05;
	localparam logic [5:0] REG_DATA_CONFIG_EXT = 6'h3F;
	// Transmit group
	localparam logic [5:0] REG_TX_DESC_UPPER_BASE = 6'h06;
	localparam logic [5:0] REG_TX_DESC_CURRENT_OFFSET = 6'h07;
	localparam logic [5:0] REG_TX_PACKET_SIZE = 6'h08;
	localparam logic [5:0] REG_TX_FRAGMENT_COUNT = 6'h09;
	localparam logic [5:0] REG_TX_START_ADDR_LOW = 6'h0A;
	localparam logic [5:0] REG_TX_START_ADDR_HIGH = 6'h0B;
	localparam logic [5:0] REG_TX_FRAGMENT_SIZE = 6'h0C;
	localparam logic [5:0] REG_TX_TEMP_DESC_ADDR = 6'h20;
	localparam logic [5:0] REG_MAX_DEFERRAL_TIMER = 6'h2F;
	// Receive group
	localparam logic [5:0] REG_RX_DESC_UPPER_BASE = 6'h0D;
	localparam logic [5:0] REG_RX_DESC_CURRENT_OFFSET = 6'h0E;
	localparam logic [5:0] REG_RX_BUF_ADDR_LOW = 6'h0F;
	localparam logic [5:0] REG_RX_BUF_ADDR_HIGH = 6'h10;
	localparam logic [5:0] REG_RX_BUF_WORDS_LEFT_LOW = 6'h11;
	localparam logic [5:0] REG_RX_BUF_WORDS_LEFT_HIGH = 6'h12;
	localparam logic [5:0] REG_END_OF_BUFFER_WORDS = 6'h13;
	localparam logic [5:0] REG_RX_RESOURCE_UPPER_BASE = 6'h14;
	localparam logic [5:0] REG_RESOURCE_START = 6'h15;
	localparam logic [5:0] REG_RESOURCE_END = 6'h16;
	localparam logic [5:0] REG_RESOURCE_READ_PTR = 6'h17;
	localparam logic [5:0] REG_RESOURCE_WRITE_PTR = 6'h18;
	localparam logic [5:0] REG_RX_TEMP_BUF_ADDR_LOW = 6'h19;
	localparam logic [5:0] REG_RX_TEMP_BUF_ADDR_HIGH = 6'h1A;
	localparam logic [5:0] REG_TEMP_BUF_WORDS_LOW = 6'h1B;
	localparam logic [5:0] REG_TEMP_BUF_WORDS_HIGH = 6'h1C;
	localparam logic [5:0] REG_ADDRESS_GENERATOR_LOW = 6'h1D;
	localparam logic [5:0] REG_ADDRESS_GENERATOR_HIGH = 6'h1E;
	localparam logic [5:0] REG_LAST_LINK_FIELD_ADDR = 6'h1F;
	localparam logic [5:0] REG_RX_SEQUENCE_COUNTER = 6'h2B;
	// CAM group
	localparam logic [5:0] REG_CAM_ENTRY_PTR = 6'h21;
	localparam logic [5:0] REG_CAM_PORT_HIGH = 6'h22;
	localparam logic [5:0] REG_CAM_PORT_MID = 6'h23;
	localparam logic [5:0] REG_CAM_PORT_LOW = 6'h24;
	localparam logic [5:0] REG_CAM_ENABLE_MASK = 6'h25;
	localparam logic [5:0] REG_CAM_DESC_PTR = 6'h26;
	localparam logic [5:0] REG_CAM_DESC_COUNT = 6'h27;
	// Revision, watchdog and tallies
	localparam logic [5:0] REG_SILICON_REVISION = 6'h28;
	localparam logic [5:0] REG_WATCHDOG_COUNT_LOW = 6'h29;
	localparam logic [5:0] REG_WATCHDOG_COUNT_HIGH = 6'h2A;
	localparam logic [5:0] REG_CRC_ERROR_TALLY = 6'h2C;
	localparam logic [5:0] REG_ALIGNMENT_ERROR_TALLY = 6'h2D;
	localparam logic [5:0] REG_MISSED_PACKET_TALLY = 6'h2E;
	// Factory test window
	localparam logic [5:0] REG_FACTORY_FIRST = 6'h30;
	localparam logic [5:0] REG_FACTORY_LAST = 6'h3E;
	// Command fields
	localparam int CMD_SOFT_RESET_BIT = 7;
	localparam logic [15:0] CMD_RESET_VALUE = 16'h0094;
	localparam logic [15:0] CMD_WRITABLE = 16'h03BF;
	localparam logic [15:0] CMD_SOFT_RESET_MASK = 16'h0080;
	localparam logic [15:0] CMD_SWRST_CLEAR = 16'h0303;
	localparam logic [15:0] CMD_SWRST_SET = 16'h0084;
	// Data configuration fields
	localparam int DCFG_WIDTH32_BIT = 5;
	localparam int FRAG_SHIFT_16 = 1;
	localparam int FRAG_SHIFT_32 = 2;
	// Reset and filler values
	localparam logic [15:0] REG_RESET_VALUE = 16'h0000;
	localparam logic [15:0] TALLY_RESET_VALUE = 16'h0000;
	localparam logic [15:0] CAM_INVALID_DATA = 16'h0000;
	localparam logic [15:0] UNMAPPED_DATA = 16'h0000;
endpackage : nic_regs_pkg

/* rtl/tally_counter.sv */
// One error tally: loads the complement of host data, counts engine events
`timescale 1ns/100ps
`default_nettype none
module tally_counter #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_data,
	input wire logic count_event,
	output logic [WIDTH-1:0] value
);
	wire logic [WIDTH-1:0] next_value;

	// Host load wins over a coincident count
	assign next_value = load ? ~load_data :
		count_event ? value + WIDTH'(1) : value;

	// Count storage
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			value <= WIDTH'(nic_regs_pkg::TALLY_RESET_VALUE);
		end else begin
			value <= next_value;
		end
	end
endmodule : tally_counter
`default_nettype wire

/* rtl/nic_register_map_decode.sv */
// Host register bank and six-bit address decode of the network controller
//
// Operation
// - Host asserts chip select with six-bit address; at most one register is selected, none in 30h-3Eh.
// - Command, status, interrupt group at 00h-05h plus extended config at 3Fh.
// - CAM port registers read valid data only while soft reset is set.
// - Tally counters store the complement of written data; reads are not inverted.
// - Transmit packet size reads back the complement of the last written value.
// - CAM enable mask takes host writes only in reset; engine loads it in either mode, but a host write in reset wins.
// - Both data configuration registers ignore writes outside reset mode.
// - Fragment size write is shifted one bit in 16-bit, two in 32-bit mode.
// - Soft reset is command bit 7; hardware reset sets it, host clears it.
`timescale 1ns/100ps
`default_nettype none
module nic_register_map_decode #(
	// Arbitrary revision value
	parameter logic [15:0] SILICON_REVISION = 16'h0001
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic chip_select,
	input wire logic read_strobe,
	input wire logic write_strobe,
	input wire logic [5:0] reg_select_pins,
	input wire logic [15:0] write_data,
	output logic [15:0] read_data,
	output logic read_valid,
	input wire logic eng_write,
	input wire logic [5:0] eng_select,
	input wire logic [15:0] eng_data,
	input wire logic [15:0] cmd_done,
	input wire logic [2:0] tally_event,
	input wire logic [47:0] cam_port_data,
	input wire logic [15:0] deferral_count,
	output logic soft_reset,
	output logic [15:0] command_register,
	output logic [15:0] data_config_register,
	output logic [15:0] data_config_ext_register,
	output logic [15:0] cam_enable_mask,
	output logic [15:0] tx_fragment_size,
	output logic bus_width32
);
	// Registers with their own write behaviour stay out of the plain array
	function automatic logic is_plain(input logic [5:0] idx);
		logic special;
		special = (idx == nic_regs_pkg::REG_COMMAND) ||
			(idx == nic_regs_pkg::REG_DATA_CONFIG) ||
			(idx == nic_regs_pkg::REG_DATA_CONFIG_EXT) ||
			(idx == nic_regs_pkg::REG_TX_PACKET_SIZE) ||
			(idx == nic_regs_pkg::REG_TX_FRAGMENT_SIZE) ||
			(idx == nic_regs_pkg::REG_CAM_PORT_HIGH) ||
			(idx == nic_regs_pkg::REG_CAM_PORT_MID) ||
			(idx == nic_regs_pkg::REG_CAM_PORT_LOW) ||
			(idx == nic_regs_pkg::REG_CAM_ENABLE_MASK) ||
			(idx == nic_regs_pkg::REG_SILICON_REVISION) ||
			(idx == nic_regs_pkg::REG_MAX_DEFERRAL_TIMER) ||
			(idx == nic_regs_pkg::REG_CRC_ERROR_TALLY) ||
			(idx == nic_regs_pkg::REG_ALIGNMENT_ERROR_TALLY) ||
			(idx == nic_regs_pkg::REG_MISSED_PACKET_TALLY) ||
			((idx >= nic_regs_pkg::REG_FACTORY_FIRST) &&
			(idx <= nic_regs_pkg::REG_FACTORY_LAST));
		return !special;
	endfunction : is_plain

	wire logic host_wr;
	wire logic host_rd;
	wire logic [5:0] sel;
	wire logic cmd_hit;
	wire logic dcfg_hit;
	wire logic dcfg_ext_hit;
	wire logic pkt_hit;
	wire logic frag_hit;
	wire logic mask_host_hit;
	wire logic mask_eng_hit;
	wire logic pkt_eng_hit;
	wire logic frag_eng_hit;
	wire logic cam_sel;
	wire logic [15:0] cam_word;
	wire logic [15:0] cmd_cmd_bits;
	wire logic [15:0] cmd_after_done;
	wire logic [15:0] cmd_with_write;
	wire logic [15:0] next_command;
	wire logic [15:0] next_fragment_size;
	wire logic [15:0] read_value;
	wire logic [15:0] plain_val [nic_regs_pkg::REG_COUNT];
	wire logic [15:0] tally_val [nic_regs_pkg::TALLY_COUNT];
	logic [15:0] tx_packet_size;

	// host strobes qualified by chip select
	assign host_wr = chip_select && write_strobe;
	assign host_rd = chip_select && read_strobe;
	assign sel = reg_select_pins;

	// one-hot decode of the special registers
	assign cmd_hit = host_wr && (sel == nic_regs_pkg::REG_COMMAND);
	assign dcfg_hit = host_wr && (sel == nic_regs_pkg::REG_DATA_CONFIG);
	assign dcfg_ext_hit = host_wr && (sel == nic_regs_pkg::REG_DATA_CONFIG_EXT);
	assign pkt_hit = host_wr && (sel == nic_regs_pkg::REG_TX_PACKET_SIZE);
	assign frag_hit = host_wr && (sel == nic_regs_pkg::REG_TX_FRAGMENT_SIZE);
	assign mask_host_hit = host_wr && (sel == nic_regs_pkg::REG_CAM_ENABLE_MASK);
	// Engine-side loads of working registers
	assign mask_eng_hit = eng_write && (eng_select == nic_regs_pkg::REG_CAM_ENABLE_MASK);
	assign pkt_eng_hit = eng_write && (eng_select == nic_regs_pkg::REG_TX_PACKET_SIZE);
	assign frag_eng_hit = eng_write && (eng_select == nic_regs_pkg::REG_TX_FRAGMENT_SIZE);

	// Soft reset state and bus width seen by the engines
	assign soft_reset = command_register[nic_regs_pkg::CMD_SOFT_RESET_BIT];
	assign bus_width32 = data_config_register[nic_regs_pkg::DCFG_WIDTH32_BIT];

	// Command bits other than soft reset are ignored while in reset
	assign cmd_cmd_bits = soft_reset ? 16'h0000 :
		(write_data & nic_regs_pkg::CMD_WRITABLE & ~nic_regs_pkg::CMD_SOFT_RESET_MASK);
	// Engine clears finished commands; host set wins over a same-cycle clear
	assign cmd_after_done = command_register & ~(cmd_done & ~nic_regs_pkg::CMD_SOFT_RESET_MASK);
	assign cmd_with_write = cmd_after_done | cmd_cmd_bits;
	// writing bit 7 enters reset, writing zero there leaves it
	assign next_command = !cmd_hit ? cmd_after_done :
		write_data[nic_regs_pkg::CMD_SOFT_RESET_BIT] ?
		((cmd_with_write & ~nic_regs_pkg::CMD_SWRST_CLEAR) | nic_regs_pkg::CMD_SWRST_SET) :
		(cmd_with_write & ~nic_regs_pkg::CMD_SOFT_RESET_MASK);

	// hardware reset sets the soft reset bit
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			command_register <= nic_regs_pkg::CMD_RESET_VALUE;
		end else begin
			command_register <= next_command;
		end
	end

	// configuration registers locked outside reset mode
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_config_register <= nic_regs_pkg::REG_RESET_VALUE;
			data_config_ext_register <= nic_regs_pkg::REG_RESET_VALUE;
		end else begin
			if (dcfg_hit && soft_reset) begin
				data_config_register <= write_data;
			end
			if (dcfg_ext_hit && soft_reset) begin
				data_config_ext_register <= write_data;
			end
		end
	end

	// host loads the CAM mask in reset only, engine in either mode, host first
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cam_enable_mask <= nic_regs_pkg::REG_RESET_VALUE;
		end else if (mask_host_hit && soft_reset) begin
			cam_enable_mask <= write_data;
		end else if (mask_eng_hit) begin
			cam_enable_mask <= eng_data;
		end
	end

	// host value converted by the bus width shift
	assign next_fragment_size = bus_width32 ?
		(write_data >> nic_regs_pkg::FRAG_SHIFT_32) :
		(write_data >> nic_regs_pkg::FRAG_SHIFT_16);

	// Packet and fragment sizes, host before engine
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_packet_size <= nic_regs_pkg::REG_RESET_VALUE;
			tx_fragment_size <= nic_regs_pkg::REG_RESET_VALUE;
		end else begin
			if (pkt_hit) begin
				tx_packet_size <= write_data;
			end else if (pkt_eng_hit) begin
				tx_packet_size <= eng_data;
			end
			if (frag_hit) begin
				tx_fragment_size <= next_fragment_size;
			end else if (frag_eng_hit) begin
				tx_fragment_size <= eng_data;
			end
		end
	end

	// Plain read/write registers, one flip-flop word per mapped index
	for (genvar i = 0; i < nic_regs_pkg::REG_COUNT; i++) begin : g_plain
		if (is_plain(6'(i))) begin : g_ff
			wire logic h_wr;
			wire logic e_wr;
			logic [15:0] q;
			assign h_wr = host_wr && (sel == 6'(i));
			// engine updates; host writes here rely on software discipline
			assign e_wr = eng_write && (eng_select == 6'(i));
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					q <= nic_regs_pkg::REG_RESET_VALUE;
				end else if (h_wr) begin
					q <= write_data;
				end else if (e_wr) begin
					q <= eng_data;
				end
			end
			assign plain_val[i] = q;
		end else begin : g_none
			// factory window and special slots hold nothing here
			assign plain_val[i] = nic_regs_pkg::UNMAPPED_DATA;
		end
	end

	// three tallies, halted while in soft reset
	for (genvar k = 0; k < nic_regs_pkg::TALLY_COUNT; k++) begin : g_tally
		wire logic load;
		wire logic count_event;
		assign load = host_wr && (sel == 6'(nic_regs_pkg::REG_CRC_ERROR_TALLY + k));
		assign count_event = tally_event[k] && !soft_reset;
		tally_counter #(
			.WIDTH(nic_regs_pkg::DATA_W)
		) u_tally (
			.clk(clk),
			.sys_rst(sys_rst),
			.load(load),
			.load_data(write_data),
			.count_event(count_event),
			.value(tally_val[k])
		);
	end

	// CAM port words, valid only in reset mode
	assign cam_sel = (sel == nic_regs_pkg::REG_CAM_PORT_HIGH) ||
		(sel == nic_regs_pkg::REG_CAM_PORT_MID) ||
		(sel == nic_regs_pkg::REG_CAM_PORT_LOW);
	assign cam_word = !soft_reset ? nic_regs_pkg::CAM_INVALID_DATA :
		(sel == nic_regs_pkg::REG_CAM_PORT_HIGH) ? cam_port_data[47:32] :
		(sel == nic_regs_pkg::REG_CAM_PORT_MID) ? cam_port_data[31:16] :
		cam_port_data[15:0];

	// read selection across the whole map
	// read-only sources have no write path
	assign read_value =
		(sel == nic_regs_pkg::REG_COMMAND) ? command_register :
		(sel == nic_regs_pkg::REG_DATA_CONFIG) ? data_config_register :
		(sel == nic_regs_pkg::REG_DATA_CONFIG_EXT) ? data_config_ext_register :
		(sel == nic_regs_pkg::REG_TX_PACKET_SIZE) ? ~tx_packet_size :
		(sel == nic_regs_pkg::REG_TX_FRAGMENT_SIZE) ? tx_fragment_size :
		(sel == nic_regs_pkg::REG_CAM_ENABLE_MASK) ? cam_enable_mask :
		cam_sel ? cam_word :
		(sel == nic_regs_pkg::REG_SILICON_REVISION) ? SILICON_REVISION :
		(sel == nic_regs_pkg::REG_MAX_DEFERRAL_TIMER) ? deferral_count :
		(sel == nic_regs_pkg::REG_CRC_ERROR_TALLY) ? tally_val[0] :
		(sel == nic_regs_pkg::REG_ALIGNMENT_ERROR_TALLY) ? tally_val[1] :
		(sel == nic_regs_pkg::REG_MISSED_PACKET_TALLY) ? tally_val[2] :
		plain_val[sel];

	// read data captured one cycle after the strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			read_data <= nic_regs_pkg::UNMAPPED_DATA;
			read_valid <= 1'b0;
		end else begin
			read_valid <= host_rd;
			if (host_rd) begin
				read_data <= read_value;
			end
		end
	end

	// Checks on the bank
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	AST_READ_ONE_CYCLE: assert property (
		host_rd |=> read_valid ##1 (read_valid == $past(host_rd)))
		else $error("read answer not one cycle after strobe");

	AST_CMD_READBACK: assert property (
		(host_rd && sel == nic_regs_pkg::REG_COMMAND && !host_wr)
		|=> read_data == $past(command_register))
		else $error("command read does not return command");

	AST_CAM_HIDDEN: assert property (
		(host_rd && cam_sel && !soft_reset)
		|=> read_data == nic_regs_pkg::CAM_INVALID_DATA)
		else $error("CAM port leaked outside reset mode");

	AST_TALLY_INVERT: assert property (
		(host_wr && sel == nic_regs_pkg::REG_CRC_ERROR_TALLY)
		|=> tally_val[0] == ~$past(write_data))
		else $error("tally did not store complement");

	AST_PKT_SIZE_INVERT: assert property (
		(pkt_hit ##1 !(pkt_hit || pkt_eng_hit) ##1
		(host_rd && sel == nic_regs_pkg::REG_TX_PACKET_SIZE))
		|=> read_data == ~$past(write_data, 3))
		else $error("packet size read not inverted");

	AST_MASK_LOCK: assert property (
		(mask_host_hit && !soft_reset && !mask_eng_hit)
		|=> $stable(cam_enable_mask))
		else $error("CAM mask written outside reset");

	AST_CONFIG_LOCK: assert property (
		((dcfg_hit || dcfg_ext_hit) && !soft_reset)
		|=> $stable(data_config_register) && $stable(data_config_ext_register))
		else $error("configuration changed outside reset");

	AST_FRAG_SHIFT: assert property (
		frag_hit |=> tx_fragment_size == ($past(bus_width32) ?
		($past(write_data) >> 2) : ($past(write_data) >> 1)))
		else $error("fragment size shift wrong");

	AST_SOFT_RESET_ENTRY: assert property (
		(cmd_hit && write_data[nic_regs_pkg::CMD_SOFT_RESET_BIT])
		|=> soft_reset && command_register[2] && !command_register[9]
		&& !command_register[0])
		else $error("software reset entry wrong");

	AST_FACTORY_ZERO: assert property (
		(host_rd && sel >= nic_regs_pkg::REG_FACTORY_FIRST &&
		sel <= nic_regs_pkg::REG_FACTORY_LAST)
		|=> read_data == nic_regs_pkg::UNMAPPED_DATA)
		else $error("factory window not silent");

	AST_CONFIG_LOAD: assert property (
		(dcfg_hit && soft_reset) |=> data_config_register == $past(write_data))
		else $error("configuration write in reset lost");

	AST_MASK_ENGINE: assert property (
		(mask_eng_hit && !(mask_host_hit && soft_reset))
		|=> cam_enable_mask == $past(eng_data))
		else $error("engine mask load lost");

	AST_TALLY_HALT: assert property (
		(soft_reset && !host_wr) |=> $stable(tally_val[0]) && $stable(tally_val[2]))
		else $error("tally moved in soft reset");

	AST_LEAVE_RESET: assert property (
		(cmd_hit && !write_data[nic_regs_pkg::CMD_SOFT_RESET_BIT]) |=> !soft_reset)
		else $error("soft reset not left on clear");

	COV_LEAVE_RESET: cover property (soft_reset ##1 !soft_reset);
	COV_CONFIG_WRITE: cover property (dcfg_hit && soft_reset);
	COV_CAM_READ: cover property (host_rd && cam_sel && soft_reset);
	COV_TALLY_COUNT: cover property (tally_event[1] && !soft_reset);
endmodule : nic_register_map_decode
`default_nettype wire

/* tb/nic_host_model.sv */
// Host processor model that drives register cycles on the select pins
`timescale 1ns/100ps
`default_nettype none
module nic_host_model (
	input wire logic clk,
	output logic chip_select,
	output logic read_strobe,
	output logic write_strobe,
	output logic [5:0] reg_select_pins,
	output logic [15:0] write_data,
	input wire logic [15:0] read_data,
	input wire logic read_valid
);
	// Idle bus from time zero
	initial begin
		chip_select = 1'b0;
		read_strobe = 1'b0;
		write_strobe = 1'b0;
		reg_select_pins = 6'h00;
		write_data = 16'h0000;
	end

	function automatic bit allowed(input logic [5:0] a);
		return !(a >= 6'h30 && a <= 6'h3E);
	endfunction : allowed

	// Deselect; scramble lines so stale values never look valid
	task automatic release_bus();
		chip_select = 1'b0;
		read_strobe = 1'b0;
		write_strobe = 1'b0;
		reg_select_pins = ~reg_select_pins;
		write_data = ~write_data;
	endtask : release_bus

	task automatic bus_write(input logic [5:0] a, input logic [15:0] d);
		if (allowed(a)) begin
			@(negedge clk);
			chip_select = 1'b1;
			write_strobe = 1'b1;
			reg_select_pins = a;
			write_data = d;
			@(negedge clk);
			release_bus();
		end
	endtask : bus_write

	task automatic bus_read(input logic [5:0] a, output logic [15:0] d, output logic v);
		d = 16'h0000;
		v = 1'b0;
		if (allowed(a)) begin
			@(negedge clk);
			chip_select = 1'b1;
			read_strobe = 1'b1;
			reg_select_pins = a;
			@(negedge clk);
			release_bus();
			d = read_data;
			v = read_valid;
		end
	endtask : bus_read
endmodule : nic_host_model
`default_nettype wire

/* tb/nic_register_map_decode_tb_top.sv */
// Self-checking bench of the host register bank with a behavioural model
`timescale 1ns/100ps
`default_nettype none
module nic_register_map_decode_tb_top;
	// Arbitrary revision value
	localparam logic [15:0] REV = 16'h5A3C;
	logic clk, sys_rst, chip_select, read_strobe, write_strobe, read_valid;
	logic soft_reset, bus_width32;
	logic [5:0] reg_select_pins;
	logic [15:0] write_data, read_data, command_register, dcfg, dcfg_ext, cam_mask, frag;
	logic [2:0] tally_event;
	logic [47:0] cam_port_data;
	logic [15:0] deferral_count;
	logic eng_write;
	logic [5:0] eng_select;
	logic [15:0] eng_data;
	logic [15:0] mem [64];
	logic [31:0] seed;
	bit in_rst;
	int mismatches, checks;

	nic_host_model u_host (.clk(clk), .chip_select(chip_select), .read_strobe(read_strobe),
		.write_strobe(write_strobe), .reg_select_pins(reg_select_pins),
		.write_data(write_data), .read_data(read_data), .read_valid(read_valid));

	nic_register_map_decode #(.SILICON_REVISION(REV)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.chip_select(chip_select), .read_strobe(read_strobe), .write_strobe(write_strobe),
		.reg_select_pins(reg_select_pins), .write_data(write_data), .read_data(read_data),
		.read_valid(read_valid), .eng_write(eng_write), .eng_select(eng_select),
		.eng_data(eng_data),
		.cmd_done(16'h0000), .tally_event(tally_event), .cam_port_data(cam_port_data),
		.deferral_count(deferral_count), .soft_reset(soft_reset),
		.command_register(command_register), .data_config_register(dcfg),
		.data_config_ext_register(dcfg_ext), .cam_enable_mask(cam_mask),
		.tx_fragment_size(frag), .bus_width32(bus_width32));

	// Free-running clock
	always #4 clk = ~clk;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Model state after a hardware reset
	function automatic void m_reset();
		foreach (mem[i]) mem[i] = 16'h0000;
		mem[0] = 16'h0094;
		in_rst = 1'b1;
	endfunction : m_reset

	// Model of a host write
	function automatic void m_write(input logic [5:0] a, input logic [15:0] d);
		logic [15:0] orv;
		orv = in_rst ? 16'h0000 : (d & 16'h03BF);
		case (a)
			6'h00: begin
				if (d[7]) mem[0] = ((mem[0] | orv) & ~16'h0303) | 16'h0084;
				else mem[0] = (mem[0] | orv) & ~16'h0080;
				in_rst = d[7];
			end
			6'h01, 6'h3F, 6'h25: if (in_rst) mem[a] = d;
			6'h0C: mem[a] = mem[1][nic_regs_pkg::DCFG_WIDTH32_BIT] ?
				d >> nic_regs_pkg::FRAG_SHIFT_32 : d >> nic_regs_pkg::FRAG_SHIFT_16;
			6'h2C, 6'h2D, 6'h2E: mem[a] = ~d;
			6'h22, 6'h23, 6'h24, 6'h28, 6'h2F: ;
			default: if (a < 6'h30) mem[a] = d;
		endcase
	endfunction : m_write

	// Model of a host read
	function automatic logic [15:0] m_read(input logic [5:0] a);
		case (a)
			6'h08: return ~mem[a];
			6'h22: return in_rst ? cam_port_data[47:32] : 16'h0000;
			6'h23: return in_rst ? cam_port_data[31:16] : 16'h0000;
			6'h24: return in_rst ? cam_port_data[15:0] : 16'h0000;
			6'h28: return REV;
			6'h2F: return deferral_count;
			default: return (a >= 6'h30) && (a <= 6'h3E) ? 16'h0000 : mem[a];
		endcase
	endfunction : m_read

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		u_host.bus_write(a, d);
		m_write(a, d);
	endtask : wr

	task automatic rd_chk(input logic [5:0] a);
		logic [15:0] d;
		logic v;
		if ((a >= 6'h30) && (a <= 6'h3E)) return;
		u_host.bus_read(a, d, v);
		check({15'h0000, v}, 16'h0001);
		check(d, m_read(a));
	endtask : rd_chk

	// One event on every tally
	task automatic pulse_tally();
		@(negedge clk) tally_event = 3'h7;
		@(negedge clk) tally_event = 3'h0;
		if (!in_rst) for (int i = 0; i < 3; i++) mem[6'h2C + i] += 16'h0001;
	endtask : pulse_tally

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize

	// Hang guard
	initial begin
		#400000;
		mismatches++;
		summarize();
	end

	// Main sequence
	initial begin
		logic [5:0] plain [20];
		plain = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h0D, 6'h0E,
			6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h21, 6'h26, 6'h27, 6'h29, 6'h2A,
			6'h2B};
		clk = 1'b0;
		sys_rst = 1'b1;
		tally_event = 3'h0;
		eng_write = 1'b0;
		eng_select = 6'h00;
		eng_data = 16'h0000;
		seed = 32'h0000_0043;
		cam_port_data = 48'h0000_0000_0000;
		deferral_count = 16'h0000;
		mismatches = 0;
		checks = 0;
		m_reset();
		repeat (4) @(posedge clk);
		@(negedge clk) sys_rst = 1'b0;
		check(command_register, 16'h0094);
		check({15'h0000, soft_reset}, 16'h0001);
		cam_port_data = 48'({xs(), xs()});
		deferral_count = 16'(xs());
		for (int a = 0; a < 64; a++) rd_chk(a[5:0]);
		// Reset-mode configuration and fragment shift in both widths
		wr(6'h01, 16'(xs()) & ~16'h0020);
		wr(6'h3F, 16'(xs()));
		wr(6'h25, 16'(xs()));
		wr(6'h0C, 16'(xs()));
		rd_chk(6'h01);
		rd_chk(6'h3F);
		rd_chk(6'h25);
		rd_chk(6'h0C);
		wr(6'h01, 16'h0020);
		wr(6'h0C, 16'(xs()) | 16'h8003);
		rd_chk(6'h0C);
		check({15'h0000, bus_width32}, 16'h0001);
		check(frag, mem[6'h0C]);
		for (int a = 6'h22; a <= 6'h24; a++) rd_chk(a[5:0]);
		for (int a = 6'h2C; a <= 6'h2E; a++) begin
			wr(a[5:0], 16'hFFFF);
			rd_chk(a[5:0]);
			wr(a[5:0], 16'(xs()));
		end
		pulse_tally();
		for (int a = 6'h2C; a <= 6'h2E; a++) rd_chk(a[5:0]);
		wr(6'h08, 16'(xs()));
		rd_chk(6'h08);
		wr(6'h28, 16'(xs()));
		wr(6'h2F, 16'(xs()));
		wr(6'h23, 16'(xs()));
		rd_chk(6'h28);
		rd_chk(6'h2F);
		rd_chk(6'h23);
		// Leave reset: guarded registers now refuse writes
		wr(6'h00, 16'h0000);
		check({15'h0000, soft_reset}, 16'h0000);
		wr(6'h01, 16'(xs()));
		wr(6'h3F, 16'(xs()));
		wr(6'h25, 16'(xs()));
		rd_chk(6'h01);
		check(dcfg, mem[1]);
		rd_chk(6'h3F);
		rd_chk(6'h25);
		check(dcfg_ext, mem[6'h3F]);
		check(cam_mask, mem[6'h25]);
		// Engine loads the mask outside reset
		@(negedge clk) eng_write = 1'b1;
		eng_select = 6'h25;
		eng_data = 16'(xs());
		mem[6'h25] = eng_data;
		@(negedge clk) eng_write = 1'b0;
		rd_chk(6'h25);
		check(cam_mask, mem[6'h25]);
		for (int a = 6'h22; a <= 6'h24; a++) rd_chk(a[5:0]);
		pulse_tally();
		for (int a = 6'h2C; a <= 6'h2E; a++) rd_chk(a[5:0]);
		// internal registers kept out of the plain sweep
		foreach (plain[i]) wr(plain[i], 16'(xs()));
		foreach (plain[i]) rd_chk(plain[i]);
		rd_chk(6'h00);
		wr(6'h00, 16'h0080);
		check(command_register, mem[0]);
		wr(6'h3F, 16'(xs()));
		rd_chk(6'h3F);
		// Second hardware reset in mid-run
		@(negedge clk) sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		m_reset();
		rd_chk(6'h00);
		rd_chk(6'h3F);
		rd_chk(6'h2C);
		summarize();
	end
endmodule : nic_register_map_decode_tb_top
`default_nettype wire
